// file: include/ssp_regs.vh
// Register map, field positions, reset values and timing counts of the serial port.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// ****************************************
// Register offsets (word index on the plain register port)
// ****************************************
`define SSP_ADDR_W 2
`define SSP_OFS_STATUS 2'h0
`define SSP_OFS_CTRL1 2'h1
`define SSP_OFS_CTRL2 2'h2
`define SSP_OFS_DATA 2'h3

// ****************************************
// Status register fields
// ****************************************
`define SSP_ST_EN 15
`define SSP_ST_SIDL 13
`define SSP_ST_ROV 6
`define SSP_ST_TBF 1
`define SSP_ST_RBF 0

// ****************************************
// Control register one fields
// ****************************************
`define SSP_C1_CLOCK_PIN_DISABLE 12
`define SSP_C1_DATA_OUT_PIN_DISABLE 11
`define SSP_C1_WORD 10
`define SSP_C1_SMP 9
`define SSP_C1_CKE 8
`define SSP_C1_SLAVE_SELECT_ENABLE 7
`define SSP_C1_CKP 6
`define SSP_C1_MSTR 5
`define SSP_C1_SEC_HI 4
`define SSP_C1_SEC_LO 2
`define SSP_C1_PRI_HI 1
`define SSP_C1_PRI_LO 0
`define SSP_C1_MASK 16'h1FFF

// ****************************************
// Control register two fields
// ****************************************
`define SSP_C2_FRAMING_ENABLE 15
`define SSP_C2_FSD 14
`define SSP_C2_FPOL 13
`define SSP_C2_FDLY 1

// ****************************************
// Reset values and timing counts
// ****************************************
`define SSP_RST_WORD 16'h0000
`define SSP_RST_C1 13'h0000
`define SSP_RST_BIT 1'b0
`define SSP_STEPS_BYTE 6'h10
`define SSP_STEPS_WORD 6'h20
`define SSP_SEC_BASE 4'h8
`define SSP_DIV_W 10

`endif

// file: rtl/ssp_clkdiv.v
// Master shift clock prescaler: one tick per primary times secondary ratio.
// Assumes the caller only asks for ticks while it runs as master.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_regs.vh"

module ssp_clkdiv (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // Control
  input wire i_run,
  input wire [1:0] i_pri,
  input wire [2:0] i_sec,
  // Half-period tick
  output reg o_tick
);

  reg [`SSP_DIV_W-1:0] cnt_r;
  wire [`SSP_DIV_W-1:0] ratio;
  wire [3:0] sec_ratio;

  // ****************************************
  // Ratio decode
  // ****************************************
  // prescale field decode
  assign sec_ratio = `SSP_SEC_BASE - {1'b0, i_sec};
  assign ratio = {6'h00, sec_ratio} << {~i_pri, 1'b0};

  always @(posedge i_clk_sys) begin
    if (i_reset || !i_run) begin
      cnt_r <= {`SSP_DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_r >= ratio - 10'h001) begin
      cnt_r <= {`SSP_DIV_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 10'h001;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ssp_port.v
// Serial peripheral port: master or slave, byte or word, optional framing.
// Assumes a plain register port on i_clk_sys and raw pins from the pads.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_regs.vh"

module ssp_port (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // Register port
  input wire [`SSP_ADDR_W-1:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Device power state
  input wire i_idle_mode,
  // Shift clock pin
  input wire i_sck,
  output reg o_sck,
  output reg o_sck_oe,
  // Data pins
  input wire i_sdi,
  output reg o_sdo,
  output reg o_sdo_oe,
  // Slave select pin
  input wire i_ss_n,
  output reg o_ss_n,
  output reg o_ss_oe
);

  // ****************************************
  // Step decode
  // ****************************************
  // output change steps
  function fn_chg;
    input [5:0] s;
    input cke;
    input [5:0] n;
    begin
      fn_chg = cke ? (s[0] && (s < n - 6'h01)) : (!s[0] && (s != 6'h00) && (s < n));
    end
  endfunction

  // sample steps, middle or end of output time
  function fn_samp;
    input [5:0] s;
    input cke;
    input endp;
    input [5:0] n;
    begin
      if (endp) begin
        fn_samp = cke ? (s[0] && (s < n)) : (!s[0] && (s != 6'h00) && (s <= n));
      end else begin
        fn_samp = (s < n) && (s[0] != cke);
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg en_r, sidl_r, rov_r, tbf_r, rbf_r;
  reg [12:0] c1_r;
  reg framing_enable_r, fsd_r, fpol_r, fdly_r;
  reg [15:0] txbuf_r, rxbuf_r, sr_r;
  reg out_r, busy_r, sck_r, fsync_r, fpend_r, sck_d_r;
  reg [5:0] step_r;
  reg [2:0] sync1_r, sync2_r;

  wire tick;
  wire sck_s = sync2_r[0];
  wire sdi_s = sync2_r[1];
  wire ss_s = sync2_r[2];

  wire clock_pin_disable = c1_r[`SSP_C1_CLOCK_PIN_DISABLE];
  wire data_out_pin_disable = c1_r[`SSP_C1_DATA_OUT_PIN_DISABLE];
  wire word = c1_r[`SSP_C1_WORD];
  wire mstr = c1_r[`SSP_C1_MSTR];
  wire clock_polarity = c1_r[`SSP_C1_CKP];
  wire slave_select_enable = c1_r[`SSP_C1_SLAVE_SELECT_ENABLE];
  // sample phase only counts in master mode
  wire input_sample_phase = c1_r[`SSP_C1_SMP] & mstr;
  wire cke = c1_r[`SSP_C1_CKE] & ~framing_enable_r;
  wire [5:0] nsteps = word ? `SSP_STEPS_WORD : `SSP_STEPS_BYTE;
  wire halt = sidl_r & i_idle_mode;
  wire desel = !mstr && slave_select_enable && !framing_enable_r && ss_s;
  wire fs_in = fpol_r ? ss_s : !ss_s;
  wire [15:0] sr_sh = {sr_r[14:0], sdi_s};
  wire top_now = word ? sr_r[15] : sr_r[7];
  wire top_sh = word ? sr_sh[15] : sr_sh[7];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge i_clk_sys) begin
        if (i_reset) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= (g == 0) ? i_sck : ((g == 1) ? i_sdi : i_ss_n);
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Master clock prescaler
  // ****************************************
  // divided master clock
  ssp_clkdiv u_div (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_run(en_r && mstr && !halt),
    .i_pri(c1_r[`SSP_C1_PRI_HI:`SSP_C1_PRI_LO]),
    .i_sec(c1_r[`SSP_C1_SEC_HI:`SSP_C1_SEC_LO]),
    .o_tick(tick)
  );

  // ****************************************
  // Shift engine step control
  // ****************************************
  wire m_act = en_r && mstr && !halt && tick;
  wire edge_s = sck_s != sck_d_r;
  wire lead_s = sck_s ^ clock_polarity;
  wire s_act = en_r && !mstr && !halt && edge_s && !desel;
  wire s_start = !busy_r && lead_s &&
    (framing_enable_r ? (fs_in && fdly_r) || fpend_r : 1'b1);
  wire m_idle_ph = sck_r == clock_polarity;
  wire m_start = !busy_r && tbf_r && m_idle_ph &&
    (framing_enable_r ? (fdly_r || fpend_r) : 1'b1);
  wire run_step = (m_act && (busy_r || m_start)) || (s_act && (busy_r || s_start));
  wire [5:0] cur = busy_r ? step_r : 6'h00;
  wire do_samp = run_step && fn_samp(cur, cke, input_sample_phase, nsteps);
  // final step adds a bit only when it is a sample step
  wire [15:0] sr_fin = do_samp ? sr_sh : sr_r;
  wire [15:0] rx_word = word ? sr_fin : {8'h00, sr_fin[7:0]};
  wire do_chg = run_step && fn_chg(cur, cke, nsteps);
  wire m_done = m_act && busy_r && (step_r == nsteps);
  wire s_done = s_act && busy_r && (step_r == nsteps - 6'h01);
  wire done = m_done || s_done;
  wire s_load = en_r && !mstr && !busy_r && tbf_r;
  wire load = (m_act && m_start) || s_load;

  always @(posedge i_clk_sys) begin
    if (i_reset || !en_r) begin
      busy_r <= 1'b0;
      step_r <= 6'h00;
      fpend_r <= 1'b0;
    end else if (desel) begin
      busy_r <= 1'b0;
      step_r <= 6'h00;
    end else if (done) begin
      busy_r <= 1'b0;
      step_r <= 6'h00;
    end else if (run_step) begin
      busy_r <= 1'b1;
      step_r <= cur + 6'h01;
      fpend_r <= 1'b0;
    end else if (framing_enable_r && !fdly_r && !busy_r) begin
      // pulse before first bit clock arms the start
      if (m_act && tbf_r && m_idle_ph) begin
        fpend_r <= 1'b1;
      end else if (s_act && lead_s && fs_in) begin
        fpend_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Shift register and data out
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      sr_r <= `SSP_RST_WORD;
      out_r <= 1'b0;
    end else if (load) begin
      // buffer to shift register, keeping a sample due at this step
      sr_r <= do_samp ? {txbuf_r[14:0], sdi_s} : txbuf_r;
      out_r <= word ? txbuf_r[15] : txbuf_r[7];
    end else begin
      if (do_samp) begin
        sr_r <= sr_sh;
      end
      if (do_chg) begin
        out_r <= do_samp ? top_sh : top_now;
      end else if (!busy_r) begin
        // first bit set up before the first clock edge
        out_r <= (mstr && tbf_r) ? (word ? txbuf_r[15] : txbuf_r[7]) : top_now;
      end
    end
  end

  // ****************************************
  // Master shift clock and frame pulse
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      sck_r <= 1'b0;
      fsync_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      if (!en_r || !mstr || clock_pin_disable) begin
        sck_r <= clock_polarity;
        fsync_r <= 1'b0;
      end else if (m_act) begin
        if (framing_enable_r || (run_step && cur < nsteps)) begin
          sck_r <= ~sck_r;
        end
        if (framing_enable_r && m_idle_ph) begin
          fsync_r <= (m_start && fdly_r) || (!busy_r && tbf_r && !fdly_r && !fpend_r);
        end
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
      o_ss_n <= 1'b1;
      o_ss_oe <= 1'b0;
    end else begin
      o_sck <= sck_r;
      o_sck_oe <= en_r && mstr && !clock_pin_disable;
      o_sdo <= out_r;
      o_sdo_oe <= en_r && !data_out_pin_disable && !desel;
      // frame pulse polarity on select pin
      o_ss_n <= fpol_r ? fsync_r : !fsync_r;
      o_ss_oe <= en_r && framing_enable_r && !fsd_r;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  wire wr_st = i_wr && (i_addr == `SSP_OFS_STATUS);
  wire wr_c1 = i_wr && (i_addr == `SSP_OFS_CTRL1);
  wire wr_c2 = i_wr && (i_addr == `SSP_OFS_CTRL2);
  wire wr_dat = i_wr && (i_addr == `SSP_OFS_DATA);
  wire rd_dat = i_rd && (i_addr == `SSP_OFS_DATA);

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      en_r <= `SSP_RST_BIT;
      sidl_r <= `SSP_RST_BIT;
      c1_r <= `SSP_RST_C1;
      framing_enable_r <= `SSP_RST_BIT;
      fsd_r <= `SSP_RST_BIT;
      fpol_r <= `SSP_RST_BIT;
      fdly_r <= `SSP_RST_BIT;
      txbuf_r <= `SSP_RST_WORD;
    end else begin
      if (wr_st) begin
        en_r <= i_wdata[`SSP_ST_EN];
        sidl_r <= i_wdata[`SSP_ST_SIDL];
      end
      if (wr_c1) begin
        c1_r <= i_wdata[12:0];
        // sample phase needs master set in the same write
        c1_r[`SSP_C1_SMP] <= i_wdata[`SSP_C1_SMP] & i_wdata[`SSP_C1_MSTR];
      end
      if (wr_c2) begin
        framing_enable_r <= i_wdata[`SSP_C2_FRAMING_ENABLE];
        fsd_r <= i_wdata[`SSP_C2_FSD];
        fpol_r <= i_wdata[`SSP_C2_FPOL];
        fdly_r <= i_wdata[`SSP_C2_FDLY];
      end
      if (wr_dat) begin
        txbuf_r <= i_wdata;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      tbf_r <= `SSP_RST_BIT;
      rbf_r <= `SSP_RST_BIT;
      rov_r <= `SSP_RST_BIT;
      rxbuf_r <= `SSP_RST_WORD;
    end else begin
      // set on write wins over move
      if (wr_dat) begin
        tbf_r <= 1'b1;
      end else if (load) begin
        tbf_r <= 1'b0;
      end
      // set on completion, clear on read
      if (done && !rbf_r) begin
        rxbuf_r <= rx_word;
        rbf_r <= 1'b1;
      end else if (rd_dat) begin
        rbf_r <= 1'b0;
      end
      // overflow drops new word, software writes zero to clear
      if (done && rbf_r) begin
        rov_r <= 1'b1;
      end else if (wr_st && !i_wdata[`SSP_ST_ROV]) begin
        rov_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= `SSP_RST_WORD;
    end else if (i_rd) begin
      case (i_addr)
        `SSP_OFS_STATUS: begin
          o_rdata <= {en_r, 1'b0, sidl_r, 6'h00, rov_r, 4'h0, tbf_r, rbf_r};
        end
        `SSP_OFS_CTRL1: begin
          o_rdata <= {3'h0, c1_r};
        end
        `SSP_OFS_CTRL2: begin
          o_rdata <= {framing_enable_r, fsd_r, fpol_r, 11'h000, fdly_r, 1'b0};
        end
        `SSP_OFS_DATA: begin
          o_rdata <= rxbuf_r;
        end
        default: begin
          o_rdata <= `SSP_RST_WORD;
        end
      endcase
    end else begin
      o_rdata <= `SSP_RST_WORD;
    end
  end

endmodule
`default_nettype wire

// file: bench/ssp_port_sva.sv
// Checker for the serial port: pin enables, clock cadence, register read-back.
// Assumes it is bound to ssp_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_regs.vh"
module ssp_port_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Register port and power state
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_idle_mode,
  // Pins
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_sdo_oe
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  logic [12:0] c1_r;
  logic en_r;
  logic arm_r;
  logic sck_q;
  int gap_r;
  int ratio;
  assign ratio = (8 - c1_r[4:2]) << (2 * (3 - c1_r[1:0]));
  // ****
  // Shadow of control writes and clock gap counter
  // ****
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      c1_r <= 13'h0000;
      en_r <= 1'h0;
      arm_r <= 1'h0;
      sck_q <= 1'h0;
      gap_r <= 0;
    end else begin
      sck_q <= o_sck;
      gap_r <= gap_r + 1;
      if (i_wr || i_idle_mode) begin
        arm_r <= 1'h0;
        gap_r <= 0;
      end else if (o_sck != sck_q) begin
        arm_r <= 1'h1;
        gap_r <= 0;
      end
      if (i_wr && i_addr == `SSP_OFS_CTRL1) begin
        c1_r <= {i_wdata[12:10], i_wdata[9] & i_wdata[5], i_wdata[8:0]};
      end
      if (i_wr && i_addr == `SSP_OFS_STATUS) begin
        en_r <= i_wdata[15];
      end
    end
  end
  AST_SLAVE_NO_SCK:
    assert property ((!c1_r[5]) [*3] |-> !o_sck_oe) else $error("clock driven as slave");
  AST_SCK_DISABLE:
    assert property ((c1_r[12]) [*3] |-> !o_sck_oe) else $error("clock pin not released");
  AST_SDO_RELEASE:
    assert property ((c1_r[11]) [*3] |-> !o_sdo_oe) else $error("data pin not released");
  AST_PORT_OFF:
    assert property ((!en_r) [*3] |-> !o_sck_oe && !o_sdo_oe) else $error("pins used while off");
  AST_HALF_PERIOD:
    assert property ((o_sck != sck_q) && arm_r && o_sck_oe |-> (gap_r + 1) % ratio == 0)
      else $error("clock edge off prescale grid");
  AST_IDLE_LEVEL:
    assert property ($rose(o_sck_oe) |-> o_sck == c1_r[6]) else $error("clock not at idle level");
  AST_CTRL_READBACK:
    assert property (i_rd && i_addr == `SSP_OFS_CTRL1 |=> o_rdata == {3'h0, c1_r})
      else $error("control read-back wrong");
  AST_STATUS_MAP:
    assert property (i_rd && i_addr == `SSP_OFS_STATUS |=> (o_rdata & 16'h5FBC) == 16'h0000
      && o_rdata[15] == en_r) else $error("status read-back wrong");
  AST_RDATA_QUIET:
    assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data without read");
endmodule
bind ssp_port ssp_port_sva i_chk (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_idle_mode, .o_sck, .o_sck_oe, .o_sdo_oe);
`default_nettype wire

// file: bench/ssp_far_model.sv
// Far-side peripheral: a plain shift-register slave on the serial pins.
// Assumes mode inputs mirror the port setup and i_clr pulses between frames.
`timescale 1ns/100ps
`default_nettype none
module ssp_far_model (
  // Pins
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi,
  // Mode and data
  input wire logic i_ckp,
  input wire logic i_cke,
  input wire logic i_word,
  input wire logic i_clr,
  input wire logic [15:0] i_tx,
  output logic [15:0] o_rx
);
  int chg_n = 0;
  int top;
  int idx;
  initial o_rx = 16'h0000;
  always @(i_sck or posedge i_clr) begin
    if (i_clr) begin
      chg_n = 0;
      o_rx = 16'h0000;
    end else if (((i_sck !== i_ckp) ^ i_cke) == 1'h1) begin
      chg_n = chg_n + 1;
    end else begin
      o_rx = {o_rx[14:0], i_sdo};
    end
  end
  // width, MSB first; inverse bit after the frame
  always @* begin
    top = i_word ? 15 : 7;
    idx = i_cke ? chg_n : (chg_n == 0 ? 0 : chg_n - 1);
    o_sdi = (idx <= top) ? i_tx[top - idx] : ~i_tx[0];
  end
endmodule
`default_nettype wire

// file: bench/tb_spi_master_slave_port.sv
// Self-checking bench for the serial port as master against a far-side slave.
// Assumes ssp_port with its checker bound, and the far-side model.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_regs.vh"
module tb_spi_master_slave_port;
  logic i_clk_sys = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_idle_mode = 0;
  logic [1:0] i_addr = 0;
  logic [15:0] i_wdata = 0, tx = 0, v, c1v, d, p;
  logic clock_polarity = 0, cke = 0, word = 0, clr = 0, rd_d = 0;
  wire [15:0] o_rdata, rx;
  wire o_sck, o_sck_oe, o_sdo, o_sdo_oe, o_ss_n, o_ss_oe, i_sdi;
  wire sck_pin = o_sck_oe ? o_sck : clock_polarity;
  wire ss_pin = o_ss_oe ? o_ss_n : 1'h1;
  wire sdo_pin = o_sdo_oe ? o_sdo : 1'h1;
  logic [31:0] notes[$];
  logic [31:0] nt;
  int fail_count = 0, tests_run = 0, cyc = 0, i;
  int unsigned seed;
  ssp_port i_dut (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_idle_mode, .i_sck(sck_pin), .o_sck, .o_sck_oe, .i_sdi, .o_sdo, .o_sdo_oe,
    .i_ss_n(ss_pin), .o_ss_n, .o_ss_oe);
  ssp_far_model i_far (.i_sck(sck_pin), .i_sdo(sdo_pin), .o_sdi(i_sdi), .i_ckp(clock_polarity),
    .i_cke(cke), .i_word(word), .i_clr(clr), .i_tx(tx), .o_rx(rx));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] dv);
    @(posedge i_clk_sys);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= dv;
    @(posedge i_clk_sys);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m,
    output logic [15:0] q);
    @(posedge i_clk_sys);
    i_rd <= 1'h1;
    i_addr <= a;
    notes.push_back({m, e & m});
    @(posedge i_clk_sys);
    i_rd <= 1'h0;
    #1 q = o_rdata;
  endtask
  task automatic wait_st(input logic [15:0] m);
    logic [15:0] q;
    int n;
    q = 0;
    n = 0;
    while ((q & m) == 0 && n < 500) begin
      rd(`SSP_OFS_STATUS, 16'h0000, 16'h0000, q);
      n++;
    end
    chk(q & m, m);
  endtask
  task automatic pulse_clr;
    clr = 1'h1;
    #1 clr = 1'h0;
  endtask
  task automatic xfer(input logic [15:0] c1, input logic [15:0] dv, input logic [15:0] pv);
    logic [15:0] q;
    logic [15:0] msk;
    msk = c1[10] ? 16'hFFFF : 16'h00FF;
    wr(`SSP_OFS_STATUS, 16'h0000);
    wr(`SSP_OFS_CTRL1, c1);
    clock_polarity = c1[6];
    cke = c1[8];
    word = c1[10];
    tx = pv;
    pulse_clr;
    wr(`SSP_OFS_DATA, dv);
    rd(`SSP_OFS_STATUS, 16'h0002, 16'h0003, q);
    wr(`SSP_OFS_STATUS, 16'h8000);
    wait_st(16'h0001);
    chk(rx & msk, dv & msk);
    rd(`SSP_OFS_DATA, pv & msk, 16'hFFFF, q);
    rd(`SSP_OFS_STATUS, 16'h8000, 16'h8043, q);
  endtask
  // ****
  // Read result monitor and timeout
  // ****
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    cyc++;
    if (rd_d) begin
      nt = notes.pop_front();
      if (nt[31:16] != 16'h0000) chk(o_rdata & nt[31:16], nt[15:0]);
    end
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    seed = $urandom(22);
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    rd(`SSP_OFS_STATUS, 16'h0000, 16'hFFFF, v);
    rd(`SSP_OFS_CTRL1, 16'h0000, 16'hFFFF, v);
    rd(`SSP_OFS_CTRL2, 16'h0000, 16'hFFFF, v);
    wr(`SSP_OFS_CTRL1, 16'hFFFF);
    rd(`SSP_OFS_CTRL1, 16'h1FFF, 16'hFFFF, v);
    wr(`SSP_OFS_CTRL1, 16'h0200);
    rd(`SSP_OFS_CTRL1, 16'h0000, 16'hFFFF, v);
    wr(`SSP_OFS_STATUS, 16'hFFFF);
    rd(`SSP_OFS_STATUS, 16'hA000, 16'hFFFF, v);
    $display("test registers done");
    wr(`SSP_OFS_CTRL2, 16'hA000);
    repeat (2) @(posedge i_clk_sys);
    chk({o_ss_oe, o_ss_n}, 16'h0002);
    wr(`SSP_OFS_CTRL2, 16'hE000);
    repeat (2) @(posedge i_clk_sys);
    chk({o_ss_oe, o_ss_n}, 16'h0000);
    wr(`SSP_OFS_CTRL2, 16'h0000);
    repeat (2) @(posedge i_clk_sys);
    chk({o_ss_oe, o_ss_n}, 16'h0001);
    wr(`SSP_OFS_CTRL1, 16'h1820);
    repeat (2) @(posedge i_clk_sys);
    chk({o_sck_oe, o_sdo_oe}, 16'h0000);
    wr(`SSP_OFS_CTRL1, 16'h0020);
    repeat (2) @(posedge i_clk_sys);
    chk({o_sck_oe, o_sdo_oe}, 16'h0003);
    $display("test pins done");
    // prescalers never both one-to-one, no framing
    for (i = 0; i < 8; i++) begin
      c1v = {5'h00, i[0], i[1] ^ i[2], i[1], 1'h0, i[2], 1'h1, i[0] ? 5'h13 : 5'h1A};
      p = 16'($urandom);
      xfer(c1v, 16'($urandom), p);
      $display("test transfer %0d done", i);
    end
    d = 16'($urandom);
    wr(`SSP_OFS_STATUS, 16'h0000);
    pulse_clr;
    i_idle_mode <= 1'h1;
    wr(`SSP_OFS_DATA, d);
    wr(`SSP_OFS_STATUS, 16'hA000);
    repeat (300) @(posedge i_clk_sys);
    rd(`SSP_OFS_STATUS, 16'h0000, 16'h0001, v);
    i_idle_mode <= 1'h0;
    wait_st(16'h0001);
    chk(rx, d);
    pulse_clr;
    wr(`SSP_OFS_DATA, ~d);
    wait_st(16'h0040);
    rd(`SSP_OFS_DATA, p, 16'hFFFF, v);
    rd(`SSP_OFS_STATUS, 16'h0040, 16'h0041, v);
    wr(`SSP_OFS_STATUS, 16'h8000);
    rd(`SSP_OFS_STATUS, 16'h0000, 16'h0040, v);
    $display("test idle and overflow done");
    repeat (2) @(posedge i_clk_sys);
    finish_test;
  end
endmodule
`default_nettype wire
